// ---- logic/rc_trim_pkg.sv ----
package rc_trim_pkg;

    // register byte addresses (low 12 bits of the bus address)
    localparam logic [11:0] ADDR_CONTROL    = 12'h080;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h084;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h088;
    localparam int          ADDR_W          = 12;

    // control register field positions
    localparam int CTL_TARGET_LSB = 0;
    localparam int CTL_WINDOW_LSB = 4;
    localparam int CTL_LIMIT_LSB  = 6;
    localparam int CTL_STOP_BIT   = 8;

    // status and enable bit positions (same layout in both)
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_FAIL_BIT = 1;
    localparam int ST_REF_BIT  = 2;

    // reset values
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [8:0]  TRIM_RST    = 9'h100;

    // target encodings
    localparam logic [1:0] TARGET_OFF  = 2'h0;
    localparam logic [1:0] TARGET_11M  = 2'h1;
    localparam logic [1:0] TARGET_12M  = 2'h2;
    localparam logic [1:0] TARGET_16M  = 2'h3;

    // oscillator ticks expected over 32 reference periods per target
    localparam logic [17:0] TICKS32_11M = 18'h02a30;
    localparam logic [17:0] TICKS32_12M = 18'h02dc7;
    localparam logic [17:0] TICKS32_16M = 18'h03d09;
    // accepted error over 32 periods: one tick per period
    localparam logic [17:0] LOCK_TOL    = 18'h00020;

    // timing: system clock and reference period in picoseconds
    localparam int CLK_PERIOD_PS = 4000;
    localparam int REF_PERIOD_PS = 30517578;
    localparam int REF_NOM_CYC   = REF_PERIOD_PS / CLK_PERIOD_PS;
    // a reference period outside 3/4 .. 5/4 of nominal is a fault
    localparam int REF_MIN_CYC   = (REF_NOM_CYC * 3) / 4;
    localparam int REF_MAX_CYC   = (REF_NOM_CYC * 5 + 3) / 4;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       err_stop;
        logic [1:0] update_limit_sel;
        logic [1:0] avg_window_sel;
        logic [1:0] target_sel;
    } trim_ctrl_t;

    typedef struct packed {
        logic ref_error_flag;
        logic trim_fail_flag;
        logic lock_flag;
    } trim_status_t;

endpackage

// ---- logic/rc_osc_auto_trim.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - stop set plus reference fault: flag, halt
// - stop clear plus fault: flag, keep trimming
// - limit field picks 64/128/256/512 updates
// - lock resets the update counter to zero
// - limit hit unlocked: stop, target cleared
// - trim from average over 4..32 reference periods
// - target field: off, 11.0592, 12, 16 MHz
// - hardware clears target on fault with stop set, or limit
// - reference error flag and enable raise irq
// - failure flag and enable raise irq
// - failure flag set on limit without lock
// - reference error with stop set halts trim, clears target
// - writing one clears the error or failure flag, zero leaves it
// - lock flag is status only, no irq
module rc_osc_auto_trim
    import rc_trim_pkg::*;
#(
    parameter int REF_MIN = REF_MIN_CYC,
    parameter int REF_MAX = REF_MAX_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // reference clock level and oscillator tick pulse
    input  wire logic        ref_clk_in,
    input  wire logic        fast_rc_osc_tick,
    // trim code to the oscillator and interrupt
    output logic [8:0]       fast_rc_osc_trim,
    output logic             irq
);

    // merge a write into a word under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // which register an address hits; 2'h3 means unmapped
    function automatic logic [1:0] reg_sel(input logic [31:0] addr);
        logic [1:0] sel;
        sel = 2'h3;
        if (addr[ADDR_W-1:0] == ADDR_CONTROL) begin
            sel = 2'h0;
        end else if (addr[ADDR_W-1:0] == ADDR_IRQ_ENABLE) begin
            sel = 2'h1;
        end else if (addr[ADDR_W-1:0] == ADDR_IRQ_STATUS) begin
            sel = 2'h2;
        end
        return sel;
    endfunction

    trim_ctrl_t   ctrl_ff;
    trim_status_t stat_ff;
    logic [1:0]   irq_en_ff;    // [1] ref error, [0] failure

    // write channel state
    logic         aw_full_ff;
    logic         w_full_ff;
    logic [31:0]  awaddr_ff;
    logic [31:0]  wdata_ff;
    logic [3:0]   wstrb_ff;
    logic         nxt_aw_full;
    logic         nxt_w_full;
    logic         nxt_bvalid;
    logic         nxt_rvalid;
    logic         wr_do;
    logic [1:0]   wr_sel;
    logic [31:0]  wr_word;

    // trim engine state
    logic         ref_prev_ff;
    logic         seen_edge_ff;
    logic [15:0]  period_cnt_ff;
    logic [4:0]   win_cnt_ff;
    logic [15:0]  acc_ff;
    logic [9:0]   upd_cnt_ff;
    logic [8:0]   trim_ff;

    logic         running;
    logic         ref_rise;
    logic         ref_fault;
    logic         halt_fault;
    logic         eval;
    logic [4:0]   win_last;
    logic [17:0]  scaled;
    logic [17:0]  target_ticks;
    logic signed [18:0] err;
    logic [17:0]  err_abs;
    logic         in_lock;
    logic [9:0]   limit;
    logic         limit_hit;

    assign running  = (ctrl_ff.target_sel != TARGET_OFF);
    assign ref_rise = ref_clk_in & ~ref_prev_ff;

    // short or missing reference periods count as a fault
    assign ref_fault = running & seen_edge_ff &
        ((ref_rise & (period_cnt_ff < 16'(REF_MIN))) |
         (~ref_rise & (period_cnt_ff == 16'(REF_MAX - 1))));
    assign halt_fault = ref_fault & ctrl_ff.err_stop;

    // window closes on the last rising edge of 4 << sel periods
    assign win_last = 5'((6'h4 << ctrl_ff.avg_window_sel) - 6'h1);
    assign eval     = running & seen_edge_ff & ref_rise &
                      (win_cnt_ff == win_last);

    // normalise the tick sum to a 32-period window
    assign scaled = 18'(acc_ff) << (2'h3 - ctrl_ff.avg_window_sel);

    // expected ticks per target frequency
    always_comb begin
        unique case (ctrl_ff.target_sel)
            TARGET_11M: target_ticks = TICKS32_11M;
            TARGET_12M: target_ticks = TICKS32_12M;
            TARGET_16M: target_ticks = TICKS32_16M;
            default:    target_ticks = 18'h0;
        endcase
    end

    assign err     = signed'({1'b0, scaled}) - signed'({1'b0, target_ticks});
    assign err_abs = err[18] ? 18'(-err) : 18'(err);
    assign in_lock = (err_abs <= LOCK_TOL);

    // update limit decode: 64 << sel
    assign limit     = 10'(11'h040 << ctrl_ff.update_limit_sel);
    assign limit_hit = eval & ~in_lock &
                       (upd_cnt_ff == limit - 10'h1);

    // ---------------------------------------------------------------
    // axi write path: address and data taken in either order
    assign wr_do   = aw_full_ff & w_full_ff & ~s_axi_bvalid;
    assign wr_sel  = reg_sel(awaddr_ff);

    always_comb begin
        nxt_aw_full = aw_full_ff;
        nxt_w_full  = w_full_ff;
        nxt_bvalid  = s_axi_bvalid;
        if (s_axi_awvalid & s_axi_awready) begin
            nxt_aw_full = 1'b1;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            nxt_w_full = 1'b1;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (wr_do) begin
            nxt_aw_full = 1'b0;
            nxt_w_full  = 1'b0;
            nxt_bvalid  = 1'b1;
        end
    end

    // write channel holding registers and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff    <= 1'b0;
            w_full_ff     <= 1'b0;
            awaddr_ff     <= 32'h0;
            wdata_ff      <= 32'h0;
            wstrb_ff      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (clk_en) begin
            aw_full_ff    <= nxt_aw_full;
            w_full_ff     <= nxt_w_full;
            s_axi_bvalid  <= nxt_bvalid;
            // ready drops while a word is held so nothing is overwritten
            s_axi_awready <= ~nxt_aw_full & ~nxt_bvalid;
            s_axi_wready  <= ~nxt_w_full & ~nxt_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_do) begin
                s_axi_bresp <= (wr_sel == 2'h3) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // word as read back, for merging strobed writes
    always_comb begin
        wr_word = merge(32'h0, wdata_ff, wstrb_ff);
        if (wr_sel == 2'h0) begin
            wr_word = merge({23'h0, ctrl_ff.err_stop,
                             ctrl_ff.update_limit_sel,
                             ctrl_ff.avg_window_sel, 2'h0,
                             ctrl_ff.target_sel},
                            wdata_ff, wstrb_ff);
        end else if (wr_sel == 2'h1) begin
            wr_word = merge({29'h0, irq_en_ff, 1'b0}, wdata_ff, wstrb_ff);
        end
    end

    // control register; hardware clear of the target beats a write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= trim_ctrl_t'(CONTROL_RST[8:0] == 9'h0 ? 7'h0 : 7'h0);
        end else if (clk_en) begin
            if (wr_do && wr_sel == 2'h0) begin
                ctrl_ff.err_stop         <= wr_word[CTL_STOP_BIT];
                ctrl_ff.update_limit_sel <= wr_word[CTL_LIMIT_LSB +: 2];
                ctrl_ff.avg_window_sel   <= wr_word[CTL_WINDOW_LSB +: 2];
                ctrl_ff.target_sel       <= wr_word[CTL_TARGET_LSB +: 2];
            end
            if (halt_fault || limit_hit) begin
                ctrl_ff.target_sel <= TARGET_OFF;
            end
        end
    end

    // interrupt enable register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_ff <= 2'h0;
        end else if (clk_en && wr_do && wr_sel == 2'h1) begin
            irq_en_ff <= {wr_word[ST_REF_BIT], wr_word[ST_FAIL_BIT]};
        end
    end

    // sticky flags: set wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_ff <= '0;
        end else if (clk_en) begin
            if (wr_do && wr_sel == 2'h2 && wstrb_ff[0]) begin
                if (wdata_ff[ST_REF_BIT]) begin
                    stat_ff.ref_error_flag <= 1'b0;
                end
                if (wdata_ff[ST_FAIL_BIT]) begin
                    stat_ff.trim_fail_flag <= 1'b0;
                end
            end
            if (ref_fault) begin
                stat_ff.ref_error_flag <= 1'b1;
            end
            if (limit_hit) begin
                stat_ff.trim_fail_flag <= 1'b1;
            end
            // lock follows the last measured window while running
            if (!running || halt_fault || limit_hit) begin
                stat_ff.lock_flag <= 1'b0;
            end else if (eval) begin
                stat_ff.lock_flag <= in_lock;
            end
        end
    end

    // interrupt: lock flag never takes part
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= (stat_ff.ref_error_flag & irq_en_ff[1]) |
                   (stat_ff.trim_fail_flag & irq_en_ff[0]);
        end
    end

    // ---------------------------------------------------------------
    // axi read path: answer one cycle after the address is taken
    assign nxt_rvalid = (s_axi_arvalid & s_axi_arready) |
                        (s_axi_rvalid & ~s_axi_rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_rvalid  <= nxt_rvalid;
            s_axi_arready <= ~nxt_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rresp <= RESP_OKAY;
                unique case (reg_sel(s_axi_araddr))
                    2'h0: s_axi_rdata <= {23'h0, ctrl_ff.err_stop,
                                          ctrl_ff.update_limit_sel,
                                          ctrl_ff.avg_window_sel, 2'h0,
                                          ctrl_ff.target_sel};
                    2'h1: s_axi_rdata <= {29'h0, irq_en_ff, 1'b0};
                    2'h2: s_axi_rdata <= {29'h0, stat_ff};
                    2'h3: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // reference edge tracking and period measurement
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_prev_ff   <= 1'b0;
            seen_edge_ff  <= 1'b0;
            period_cnt_ff <= 16'h0;
        end else if (clk_en) begin
            ref_prev_ff <= ref_clk_in;
            if (!running) begin
                // first period after enabling is never judged
                seen_edge_ff  <= 1'b0;
                period_cnt_ff <= 16'h0;
            end else if (ref_rise) begin
                seen_edge_ff  <= 1'b1;
                period_cnt_ff <= 16'h0;
            end else if (period_cnt_ff == 16'(REF_MAX - 1)) begin
                period_cnt_ff <= 16'h0; // restart so a dead clock repeats
            end else begin
                period_cnt_ff <= period_cnt_ff + 16'h1;
            end
        end
    end

    // averaging window: count periods and oscillator ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_cnt_ff <= 5'h0;
            acc_ff     <= 16'h0;
        end else if (clk_en) begin
            if (!running || !seen_edge_ff) begin
                win_cnt_ff <= 5'h0;
                acc_ff     <= 16'h0;
            end else if (eval) begin
                win_cnt_ff <= 5'h0;
                acc_ff     <= {15'h0, fast_rc_osc_tick};
            end else begin
                if (ref_rise) begin
                    win_cnt_ff <= win_cnt_ff + 5'h1;
                end
                if (acc_ff != 16'hffff) begin
                    acc_ff <= acc_ff + {15'h0, fast_rc_osc_tick};
                end
            end
        end
    end

    // trim value and update counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_ff    <= TRIM_RST;
            upd_cnt_ff <= 10'h0;
        end else if (clk_en) begin
            if (!running) begin
                upd_cnt_ff <= 10'h0;
            end else if (eval && in_lock) begin
                upd_cnt_ff <= 10'h0;
            end else if (eval && !halt_fault) begin
                upd_cnt_ff <= upd_cnt_ff + 10'h1;
                // too many ticks means too fast: lower the code
                if (!err[18] && trim_ff != 9'h000) begin
                    trim_ff <= trim_ff - 9'h1;
                end else if (err[18] && trim_ff != 9'h1ff) begin
                    trim_ff <= trim_ff + 9'h1;
                end
            end
        end
    end

    // trim code to the oscillator, held when trimming stops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_rc_osc_trim <= TRIM_RST;
        end else if (clk_en) begin
            fast_rc_osc_trim <= trim_ff;
        end
    end

endmodule // rc_osc_auto_trim

// ---- dv/rc_trim_assertions.sv ----
`timescale 1ns/10ps
module rc_trim_assertions
    import rc_trim_pkg::*;
#(
    parameter int REF_MIN = 8,
    parameter int REF_MAX = 40
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        ref_clk_in,
    input wire logic        fast_rc_osc_tick,
    input wire logic [8:0]  fast_rc_osc_trim,
    input wire logic        irq
);
    logic [31:0] aw_addr_ff;
    logic [31:0] wd_ff;
    logic [2:1]  en_ff;
    logic        b_seen_ff;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    function automatic logic mapped(input logic [31:0] a);
        return a[11:0] inside {ADDR_CONTROL, ADDR_IRQ_ENABLE, ADDR_IRQ_STATUS};
    endfunction

    // shadow of the enable bits, taken when the write answer appears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_ff <= 32'h0;
            wd_ff <= 32'h0;
            en_ff <= 2'h0;
            b_seen_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_addr_ff <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata;
            b_seen_ff <= s_axi_bvalid;
            if (s_axi_bvalid && !b_seen_ff && aw_addr_ff[11:0] == ADDR_IRQ_ENABLE)
                en_ff <= wd_ff[2:1];
        end
    end

    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // two cycles of margin cover the registered irq path
    sequence en_off_2;
        (en_ff == 2'h0) [*2];
    endsequence

    a_write_answer: assert property (aw_w_taken |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write answer not two cycles after the take");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not free after response");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_bresp_code: assert property ($rose(s_axi_bvalid)
        |-> s_axi_bresp == (mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR))
        else $error("wrong write response code");
    a_read_answer: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after the take");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not free after data");
    a_rresp_code: assert property (ar_taken |=> (mapped($past(s_axi_araddr))
        ? s_axi_rresp == RESP_OKAY
        : (s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)))
        else $error("wrong read response or data");
    a_enable_reads: assert property (ar_taken and s_axi_araddr[11:0] == ADDR_IRQ_ENABLE
        |=> s_axi_rdata[31:3] == 29'h0 && !s_axi_rdata[0])
        else $error("unused enable bits read nonzero");
    a_irq_masked: assert property (en_off_2 |-> !irq)
        else $error("irq high with all enables clear");
    a_reset_values: assert property ($rose(aresetn) |-> fast_rc_osc_trim == TRIM_RST
        && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not at reset values");
endmodule // rc_trim_assertions

bind rc_osc_auto_trim rc_trim_assertions #(.REF_MIN(REF_MIN), .REF_MAX(REF_MAX))
    i_rc_trim_assertions (.*);

// ---- dv/rc_osc_auto_trim_bench.sv ----
`timescale 1ns/10ps
module rc_osc_auto_trim_bench;
    import rc_trim_pkg::*;

    localparam int REF_HI = 400;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [1:0]  resp;
    } reg_row_t;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        clk_en = 1'b1;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        ref_clk_in = 1'b0, fast_rc_osc_tick = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [8:0]  fast_rc_osc_trim;
    int          failures = 0, n_checks = 0, ph = 0, ref_period = 20;
    logic        ref_run = 1'b0, tick_on = 1'b0;
    logic [31:0] data;
    logic [1:0]  resp;

    // plain register accesses: written value, read-back, response code
    reg_row_t rows [6] = '{
        '{12'h080, 32'h0000_01f0, 32'h0000_01f0, RESP_OKAY},
        '{12'h084, 32'hffff_ffff, 32'h0000_0006, RESP_OKAY},
        '{12'h084, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
        '{12'h088, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY},
        '{12'h100, 32'hffff_ffff, 32'h0000_0000, RESP_SLVERR},
        '{12'h080, 32'h0000_0000, 32'h0000_0000, RESP_OKAY}};

    rc_osc_auto_trim #(.REF_MIN(8), .REF_MAX(REF_HI)) i_rc_osc_auto_trim (.*);

    always #2 aclk = ~aclk;

    // reference and ticks; a stopped reference idles low, no rises
    always @(posedge aclk) begin
        // >= so a shorter period after a long one still wraps
        ph <= (!ref_run || ph >= ref_period - 1) ? 0 : ph + 1;
        ref_clk_in <= ref_run && (ph >= ref_period / 2);
        fast_rc_osc_tick <= tick_on;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {20'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw_done) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_done) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {20'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic [31:0] mask);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(d & mask, exp);
    endtask

    task automatic wait_rises(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic stop_test;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // bounds the whole run well above the ~40k cycles it needs
    initial begin
        repeat (90000) @(posedge aclk);
        failures++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        check(fast_rc_osc_trim, TRIM_RST);
        for (int a = 0; a < 3; a++) rd_chk(12'h080 + 12'(a * 4), 32'h0, 32'hffff_ffff);
        foreach (rows[i]) begin
            axi_wr(rows[i].addr, rows[i].wdata, resp);
            check(resp, rows[i].resp);
            axi_rd(rows[i].addr, data, resp);
            check(data, rows[i].rdata);
            check(resp, rows[i].resp);
        end
        // lock per window size; ticks fit the 12 MHz target closely
        wr(ADDR_IRQ_ENABLE, 32'h6);
        ref_period = 366;
        tick_on = 1'b1;
        ref_run = 1'b1;
        for (int w = 0; w < 4; w++) begin
            wr(ADDR_CONTROL, 32'h2 | (w << 4));
            // one short: a rise during the write may go uncounted here
            wait_rises((4 << w) - 1);
            rd_chk(ADDR_IRQ_STATUS, 32'h0, 32'h1);
            wait_rises(2);
            rd_chk(ADDR_IRQ_STATUS, 32'h1, 32'h7);
            check(irq, 1'b0);
            wr(ADDR_CONTROL, 32'h0);
        end
        // no ticks: every window too slow, trim climbs until the limit
        tick_on = 1'b0;
        ref_period = 20;
        for (int n = 0; n < 2; n++) begin
            wr(ADDR_CONTROL, 32'h1 | (n << 6));
            wait_rises((64 << n) * 4 - 8);
            rd_chk(ADDR_IRQ_STATUS, 32'h0, 32'h2);
            wait_rises(16);
            rd_chk(ADDR_IRQ_STATUS, 32'h2, 32'h7);
            rd_chk(ADDR_CONTROL, 32'h0, 32'h3);
            check(fast_rc_osc_trim, TRIM_RST + 64 * ((2 << n) - 1));
            check(irq, 1'b1);
            wr(ADDR_IRQ_STATUS, 32'h0);
            rd_chk(ADDR_IRQ_STATUS, 32'h2, 32'h2);
            wr(ADDR_IRQ_STATUS, 32'h2);
            rd_chk(ADDR_IRQ_STATUS, 32'h0, 32'h2);
            check(irq, 1'b0);
        end
        // reference dies mid-trim, with and without stop-on-error
        for (int s = 1; s >= 0; s--) begin
            ref_run = 1'b1;
            wr(ADDR_CONTROL, 32'h3 | (s << 8));
            wait_rises(2);
            ref_run = 1'b0;
            repeat (REF_HI + 20) @(posedge aclk);
            rd_chk(ADDR_IRQ_STATUS, 32'h4, 32'h4);
            rd_chk(ADDR_CONTROL, s ? 32'h0 : 32'h3, 32'h3);
            check(irq, 1'b1);
            for (int e = 0; e < 8; e += 2) begin
                wr(ADDR_IRQ_ENABLE, e);
                repeat (2) @(posedge aclk);
                check(irq, e[2]);
            end
            wr(ADDR_CONTROL, 32'h0);
            wr(ADDR_IRQ_STATUS, 32'h4);
            rd_chk(ADDR_IRQ_STATUS, 32'h0, 32'h4);
        end
        stop_test();
    end
endmodule // rc_osc_auto_trim_bench
